// *** verilog/sltc_host.sv ***
// sltc_host: receiving-end controller for at-speed self-test of a serial link.
// assumes link words arrive synchronous to I_CLK with frame-end marks, and
// the link transmitter obeys the back-channel test command and clock select.
`timescale 1ns/10ps
module sltc_host
	import sltc_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RESETN,
	input wire logic [7:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	input wire logic I_SELFTEST_ENABLE_PIN,
	input wire logic [1:0] I_CLKSEL_PIN,
	input wire logic I_LINK_LOCK,
	input wire logic I_LINK_VALID,
	input wire logic [11:0] I_LINK_DATA,
	input wire logic I_LINK_LAST,
	output logic O_LINK_READY,
	output logic O_BIST_CMD,
	output logic [1:0] O_OSC_SEL,
	output logic O_RESULT
);
	sltc_state_t state;
	sltc_state_t next_state;
	logic ctrl_en;
	logic [1:0] ctrl_sel;
	logic ctrl_regmode;
	logic test_en;
	logic [1:0] sel_eff;
	logic [ERRCNT_W-1:0] err_cnt;
	logic [WORD_W-1:0] lfsr;
	logic frame_err;
	logic fifo_valid;
	logic [WORD_W:0] fifo_data;
	logic chk_pop;
	logic mism;
	logic frame_bad;
	logic session_start;
	logic bus_req;
	logic bus_go;
	logic [31:0] next_rdata;

	// configuration source: pins unless register mode set
	assign test_en = ctrl_regmode ? ctrl_en : I_SELFTEST_ENABLE_PIN;
	always_comb
	begin
		if (!ctrl_regmode)
			sel_eff = I_CLKSEL_PIN;
		else if (ctrl_sel == SEL_RSVD)
			sel_eff = SEL_PCLK;
		else
			sel_eff = ctrl_sel;
	end

	// avalon slave: one wait cycle, then the answer
	assign bus_req = I_AVS_READ || I_AVS_WRITE;
	assign bus_go = bus_req && !O_AVS_WAITREQUEST;

	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
			O_AVS_WAITREQUEST <= 1'b1;
		else if (bus_req && O_AVS_WAITREQUEST)
			O_AVS_WAITREQUEST <= 1'b0;
		else
			O_AVS_WAITREQUEST <= 1'b1;
	end

	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			ctrl_en <= CTRL_RESET[CTRL_EN_BIT];
			ctrl_sel <= CTRL_RESET[CTRL_SEL_MSB:CTRL_SEL_LSB];
			ctrl_regmode <= CTRL_RESET[CTRL_REGMODE_BIT];
		end
		else if (bus_go && I_AVS_WRITE && I_AVS_ADDRESS == REG_CTRL_IDX && I_AVS_BYTEENABLE[0])
		begin
			ctrl_en <= I_AVS_WRITEDATA[CTRL_EN_BIT];
			ctrl_sel <= I_AVS_WRITEDATA[CTRL_SEL_MSB:CTRL_SEL_LSB];
			ctrl_regmode <= I_AVS_WRITEDATA[CTRL_REGMODE_BIT];
		end
	end

	always_comb
	begin
		next_rdata = '0;
		case (I_AVS_ADDRESS)
			REG_CTRL_IDX:
			begin
				next_rdata[CTRL_EN_BIT] = ctrl_en;
				next_rdata[CTRL_SEL_MSB:CTRL_SEL_LSB] = ctrl_sel;
				next_rdata[CTRL_REGMODE_BIT] = ctrl_regmode;
			end
			REG_ERRCNT_IDX:
				next_rdata[ERRCNT_W-1:0] = err_cnt;
			REG_STATUS_IDX:
			begin
				next_rdata[STAT_STATE_MSB:STAT_STATE_LSB] = state;
				next_rdata[STAT_LOCK_BIT] = I_LINK_LOCK;
				next_rdata[STAT_ACTIVE_BIT] = test_en;
				next_rdata[STAT_READY_BIT] = O_LINK_READY;
			end
			default:
				next_rdata = '0;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
			O_AVS_READDATA <= '0;
		else if (I_AVS_READ && O_AVS_WAITREQUEST)
			O_AVS_READDATA <= next_rdata;
	end

	// link words buffered; checker stalls the fifo while pulsing
	sltc_fifo #(
		.WIDTH(WORD_W+1),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(I_CLK),
		.i_resetn(I_RESETN),
		.i_flush(session_start),
		.i_in_valid(I_LINK_VALID),
		.i_in_data({I_LINK_LAST, I_LINK_DATA}),
		.o_in_ready(O_LINK_READY),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(state == ST_CHECK)
	);

	assign chk_pop = fifo_valid && state == ST_CHECK;
	assign mism = fifo_data[WORD_W-1:0] != lfsr;
	assign frame_bad = chk_pop && fifo_data[WORD_W] && (frame_err || mism);
	assign session_start = state == ST_IDLE && test_en;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (test_en)
					next_state = ST_ARM;
			ST_ARM:
				if (!test_en)
					next_state = ST_DONE;
				else if (I_LINK_LOCK)
					next_state = ST_CHECK;
			ST_CHECK:
				if (!test_en)
					next_state = ST_DONE;
				else if (!I_LINK_LOCK)
					next_state = ST_ARM;
				else if (frame_bad)
					next_state = ST_PULSE;
			ST_PULSE:
				next_state = test_en ? ST_GAP : ST_DONE;
			ST_GAP:
				next_state = test_en ? ST_CHECK : ST_DONE;
			ST_DONE:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// pattern checker; pattern restarts at every frame
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			lfsr <= PAT_SEED;
			frame_err <= 1'b0;
		end
		else if (state == ST_ARM)
		begin
			lfsr <= PAT_SEED;
			frame_err <= 1'b0;
		end
		else if (chk_pop)
		begin
			if (fifo_data[WORD_W])
			begin
				lfsr <= PAT_SEED;
				frame_err <= 1'b0;
			end
			else
			begin
				lfsr <= {lfsr[WORD_W-2:0], ^(lfsr & PAT_TAPS)};
				frame_err <= frame_err || mism;
			end
		end
	end

	// count survives the end of the test; only reset or a new session clears it
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
			err_cnt <= ERRCNT_RESET;
		else if (session_start)
			err_cnt <= ERRCNT_RESET;
		else if (state == ST_CHECK && test_en && I_LINK_LOCK && frame_bad && err_cnt != ERRCNT_MAX)
			err_cnt <= err_cnt + ERRCNT_W'(1);
	end

	// back channel: command and clock select toward the transmitter
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			O_BIST_CMD <= 1'b0;
			O_OSC_SEL <= SEL_PCLK;
		end
		else
		begin
			O_BIST_CMD <= next_state inside {ST_ARM, ST_CHECK, ST_PULSE, ST_GAP};
			if (session_start)
				O_OSC_SEL <= sel_eff;
		end
	end

	// result pin: high while checking, low pulse per bad frame
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
			O_RESULT <= 1'b0;
		else
		begin
			case (next_state)
				ST_CHECK, ST_GAP:
					O_RESULT <= 1'b1;
				ST_PULSE:
					O_RESULT <= 1'b0;
				ST_DONE:
					O_RESULT <= err_cnt == ERRCNT_RESET;
				default:
					O_RESULT <= 1'b0;
			endcase
		end
	end

	sequence s_bad_pulse;
		!O_RESULT ##1 O_RESULT;
	endsequence

	sequence s_done_once;
		state == ST_DONE ##1 state == ST_IDLE;
	endsequence

	property p_pin_config;
		@(posedge I_CLK) disable iff (!I_RESETN)
		!ctrl_regmode && state == ST_IDLE |=> (state == ST_ARM) == $past(I_SELFTEST_ENABLE_PIN);
	endproperty
	a_pin_config: assert property (p_pin_config) else $error("pin config not used");

	property p_ctrl_write;
		@(posedge I_CLK) disable iff (!I_RESETN)
		bus_go && I_AVS_WRITE && I_AVS_ADDRESS == REG_CTRL_IDX && I_AVS_BYTEENABLE[0]
		|=> ctrl_regmode == $past(I_AVS_WRITEDATA[CTRL_REGMODE_BIT]) && ctrl_en == $past(I_AVS_WRITEDATA[0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_osc_sel;
		@(posedge I_CLK) disable iff (!I_RESETN)
		session_start |=> O_OSC_SEL == $past(sel_eff) && O_OSC_SEL != SEL_RSVD;
	endproperty
	a_osc_sel: assert property (p_osc_sel) else $error("clock select not sent");

	property p_bad_frame;
		@(posedge I_CLK) disable iff (!I_RESETN)
		state == ST_CHECK && test_en && I_LINK_LOCK && frame_bad |=> s_bad_pulse;
	endproperty
	a_bad_frame: assert property (p_bad_frame) else $error("no pulse for bad frame");

	property p_done;
		@(posedge I_CLK) disable iff (!I_RESETN)
		state != ST_IDLE && state != ST_DONE && !test_en |=> s_done_once;
	endproperty
	a_done: assert property (p_done) else $error("final result not one cycle");

	property p_count_hold;
		@(posedge I_CLK) disable iff (!I_RESETN)
		state == ST_IDLE && !test_en |=> $stable(err_cnt);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("error count changed idle");

	property p_count_read;
		@(posedge I_CLK) disable iff (!I_RESETN)
		I_AVS_READ && O_AVS_WAITREQUEST && I_AVS_ADDRESS == REG_ERRCNT_IDX
		|=> O_AVS_READDATA == {24'h000000, $past(err_cnt)} && !O_AVS_WAITREQUEST;
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read wrong");

	property p_lock_start;
		@(posedge I_CLK) disable iff (!I_RESETN)
		state == ST_ARM && test_en && I_LINK_LOCK |=> state == ST_CHECK && O_RESULT && O_BIST_CMD;
	endproperty
	a_lock_start: assert property (p_lock_start) else $error("check did not start");

	property p_normal;
		@(posedge I_CLK) disable iff (!I_RESETN)
		state == ST_DONE |-> !O_BIST_CMD ##1 !O_BIST_CMD;
	endproperty
	a_normal: assert property (p_normal) else $error("link not returned to normal");

	property p_pattern;
		@(posedge I_CLK) disable iff (!I_RESETN)
		chk_pop && !fifo_data[WORD_W] && mism |=> frame_err;
	endproperty
	a_pattern: assert property (p_pattern) else $error("mismatch not flagged");
endmodule // sltc_host

// *** verilog/sltc_pkg.sv ***
// sltc_pkg: constants shared by the self-test link controller and its fifo.
// assumes one 100 MHz clock; register indices are avalon word addresses.
package sltc_pkg;
	// clock and bus
	localparam int CLK_PERIOD_NS = 10;
	localparam int AVS_ADDR_W = 8;
	localparam int AVS_DATA_W = 32;
	// register indices
	localparam logic [7:0] REG_STATUS_IDX = 8'h01;
	localparam logic [7:0] REG_ERRCNT_IDX = 8'h57;
	localparam logic [7:0] REG_CTRL_IDX = 8'hB3;
	// control register fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SEL_LSB = 1;
	localparam int CTRL_SEL_MSB = 2;
	localparam int CTRL_REGMODE_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	// clock select codes
	localparam logic [1:0] SEL_PCLK = 2'h0;
	localparam logic [1:0] SEL_RSVD = 2'h3;
	// status register fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_STATE_MSB = 2;
	localparam int STAT_LOCK_BIT = 3;
	localparam int STAT_ACTIVE_BIT = 4;
	localparam int STAT_READY_BIT = 5;
	// error counter
	localparam int ERRCNT_W = 8;
	localparam logic [7:0] ERRCNT_RESET = 8'h00;
	localparam logic [7:0] ERRCNT_MAX = 8'hFF;
	// link words and the shared test pattern
	localparam int WORD_W = 12;
	localparam int FIFO_DEPTH = 16;
	localparam logic [11:0] PAT_SEED = 12'hACE;
	localparam logic [11:0] PAT_TAPS = 12'h829;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ARM = 3'b001,
		ST_CHECK = 3'b010,
		ST_PULSE = 3'b011,
		ST_GAP = 3'b100,
		ST_DONE = 3'b101
	} sltc_state_t;
endpackage

// *** verilog/sltc_fifo.sv ***
// sltc_fifo: synchronous fifo with valid/ready on both sides.
// assumes one clock; flush drops all content in one cycle.
`timescale 1ns/10ps
module sltc_fifo
	import sltc_pkg::*;
#(
	parameter int WIDTH = 13,
	parameter int DEPTH = 16
)(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_flush,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem[rd_ptr];

	always_comb
	begin
		next_count = count;
		if (push && !pop)
			next_count = count + (AW+1)'(1);
		else if (pop && !push)
			next_count = count - (AW+1)'(1);
	end

	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			o_in_ready <= 1'b0;
			o_out_valid <= 1'b0;
		end
		else if (i_flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			o_in_ready <= 1'b1;
			o_out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + AW'(1);
			if (pop)
				rd_ptr <= rd_ptr + AW'(1);
			count <= next_count;
			// registered flags: full and empty known one cycle ahead
			o_in_ready <= next_count != DEPTH_C;
			o_out_valid <= next_count != '0;
		end
	end
endmodule // sltc_fifo

// *** tb/sltc_tx_model.sv ***
// sltc_tx_model: link transmitter on the far side of the self-test controller.
// assumes the receiver's command, select and ready arrive on the one system clock.
`timescale 1ns/10ps
module sltc_tx_model
	import sltc_pkg::*;
#(
	parameter int FRAME_LEN = 4
)(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_cmd,
	input wire logic [1:0] i_osc_sel,
	input wire logic i_ready,
	input wire logic i_lock_en,
	input wire logic i_corrupt,
	input wire logic i_slow,
	output logic o_lock,
	output logic o_valid,
	output logic [11:0] o_data,
	output logic o_last,
	output logic [1:0] o_osc,
	output logic [7:0] o_bad_cnt
);
	logic [11:0] pat;
	int idx;
	logic cmd_d;
	logic bad;
	logic acc;
	assign acc = o_valid & i_ready;
	// one clock stands for both oscillator and pixel clock, so both are present
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_lock <= 1'b0;
			o_valid <= 1'b0;
			o_data <= 12'hFFF;
			o_last <= 1'b0;
			o_osc <= 2'h0;
			o_bad_cnt <= 8'h00;
			pat <= PAT_SEED;
			idx <= 0;
			cmd_d <= 1'b0;
			bad <= 1'b0;
		end
		else
		begin
			cmd_d <= i_cmd;
			o_lock <= i_cmd & i_lock_en;
			if (acc && o_last && bad)
				o_bad_cnt <= o_bad_cnt + 8'h01;
			if (i_cmd && !cmd_d)
			begin
				o_osc <= i_osc_sel;
				o_bad_cnt <= 8'h00;
			end
			if (!i_cmd)
			begin
				// idle data keeps changing so a stale word is never mistaken for a fresh one
				o_valid <= 1'b0;
				o_data <= ~o_data;
				pat <= PAT_SEED;
				idx <= 0;
			end
			else if (!o_valid || acc)
			begin
				if (i_slow && o_valid)
				begin
					o_valid <= 1'b0;
					o_data <= ~o_data;
				end
				else
				begin
					o_valid <= 1'b1;
					o_data <= (i_corrupt && idx == 1) ? (pat ^ 12'h001) : pat;
					o_last <= (idx == FRAME_LEN - 1);
					if (idx == 0)
						bad <= 1'b0;
					if (idx == 1)
						bad <= i_corrupt;
					pat <= (idx == FRAME_LEN - 1) ? PAT_SEED : {pat[10:0], ^(pat & PAT_TAPS)};
					idx <= (idx == FRAME_LEN - 1) ? 0 : idx + 1;
				end
			end
		end
	end
endmodule // sltc_tx_model

// *** tb/tb.sv ***
// tb: self-checking bench for the self-test link controller.
// assumes an avalon master with one request at a time and the transmitter model.
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb
	import sltc_pkg::*;
;
	logic clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0, en_pin = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [3:0] be = 4'hF;
	logic [1:0] sel_pin = 2'h0;
	logic waitreq, lock, lvalid, llast, lready, cmd, result, lock_en = 1'b1, corrupt = 1'b0, slow = 1'b0;
	logic [11:0] ldata;
	logic [1:0] osc_sel, osc_seen;
	logic [7:0] bad_cnt;
	logic in_run = 1'b0, prev_res = 1'b0;
	int errors = 0, check_count = 0, pulses = 0, taken = 0, cyc = 0;
	always #5 clk = ~clk;
	sltc_host u_dut (.I_CLK(clk), .I_RESETN(resetn), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
		.I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
		.O_AVS_WAITREQUEST(waitreq), .I_SELFTEST_ENABLE_PIN(en_pin), .I_CLKSEL_PIN(sel_pin),
		.I_LINK_LOCK(lock), .I_LINK_VALID(lvalid), .I_LINK_DATA(ldata), .I_LINK_LAST(llast),
		.O_LINK_READY(lready), .O_BIST_CMD(cmd), .O_OSC_SEL(osc_sel), .O_RESULT(result));
	sltc_tx_model u_tx (.i_clk(clk), .i_resetn(resetn), .i_cmd(cmd), .i_osc_sel(osc_sel),
		.i_ready(lready), .i_lock_en(lock_en), .i_corrupt(corrupt), .i_slow(slow), .o_lock(lock),
		.o_valid(lvalid), .o_data(ldata), .o_last(llast), .o_osc(osc_seen), .o_bad_cnt(bad_cnt));
	always @(posedge clk)
	begin
		cyc++;
		if (in_run && prev_res === 1'b1 && result === 1'b0)
			pulses++;
		if (lvalid === 1'b1 && lready === 1'b1)
			taken++;
		prev_res = result;
		if (cyc == 30000)
		begin
			errors++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		be <= b;
		rd <= !w;
		wr <= w;
		do @(posedge clk); while (waitreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic start_run(input logic [1:0] exp_sel);
		for (int i = 0; i < 80 && result !== 1'b1; i++)
			@(posedge clk);
		`CHK(result, 1'b1)
		`CHK(cmd, 1'b1)
		`CHK(osc_sel, exp_sel)
		`CHK(osc_seen, exp_sel)
		pulses = 0;
		in_run = 1'b1;
	endtask
	task automatic stop_run(input logic by_reg, input logic exp_pass);
		in_run = 1'b0;
		if (by_reg)
			av(1'b1, REG_CTRL_IDX, 32'h8, 4'hF);
		else
			@(posedge clk) en_pin <= 1'b0;
		for (int i = 0; i < 20 && cmd !== 1'b0; i++)
			@(posedge clk);
		`CHK(cmd, 1'b0)
		`CHK(result, exp_pass)
		@(posedge clk);
		`CHK(result, 1'b0)
	endtask
	task automatic t_reset();
		av(1'b0, REG_STATUS_IDX, 32'h0, 4'hF);
		`CHK(q[5:0], 6'h20)
		av(1'b0, REG_CTRL_IDX, 32'h0, 4'hF);
		`CHK(q[3:0], CTRL_RESET)
		av(1'b1, 8'h10, 32'hF, 4'hF);
		av(1'b0, 8'h10, 32'h0, 4'hF);
		`CHK(q, 32'h0)
		$display("test reset done");
	endtask
	task automatic t_pin(input logic [1:0] s, input int bad_cycles);
		@(posedge clk);
		sel_pin <= s;
		en_pin <= 1'b1;
		start_run(s);
		@(posedge clk) corrupt <= (bad_cycles > 0);
		repeat (bad_cycles) @(posedge clk);
		corrupt <= 1'b0;
		repeat (80) @(posedge clk);
		`CHK(8'(pulses), bad_cnt)
		`CHK(bad_cnt >= 8'h03 || bad_cycles == 0, 1'b1)
		stop_run(1'b0, bad_cycles == 0);
		repeat (20) @(posedge clk);
		av(1'b0, REG_ERRCNT_IDX, 32'h0, 4'hF);
		`CHK(q[7:0], bad_cnt)
		$display("test pin session done");
	endtask
	task automatic t_reg();
		logic [1:0] e;
		av(1'b1, REG_CTRL_IDX, 32'h8, 4'hF);
		@(posedge clk) en_pin <= 1'b1;
		repeat (10) @(posedge clk);
		`CHK(cmd, 1'b0)
		en_pin <= 1'b0;
		av(1'b1, REG_CTRL_IDX, 32'hD, 4'hE);
		av(1'b0, REG_CTRL_IDX, 32'h0, 4'hF);
		`CHK(q[3:0], 4'h8)
		for (int s = 0; s < 4; s++)
		begin
			e = (s == 3) ? SEL_PCLK : 2'(s);
			av(1'b1, REG_CTRL_IDX, 32'h9 | (32'(s) << 1), 4'h1);
			start_run(e);
			av(1'b0, REG_ERRCNT_IDX, 32'h0, 4'hF);
			`CHK(q[7:0], ERRCNT_RESET)
			repeat (30) @(posedge clk);
			stop_run(1'b1, 1'b1);
		end
		av(1'b1, REG_CTRL_IDX, 32'h0, 4'hF);
		$display("test register mode done");
	endtask
	task automatic t_fill();
		@(posedge clk);
		lock_en <= 1'b0;
		sel_pin <= 2'h0;
		en_pin <= 1'b1;
		taken = 0;
		for (int i = 0; i < 60 && !(cmd === 1'b1 && lready === 1'b0); i++)
			@(posedge clk);
		`CHK(lready, 1'b0)
		`CHK(taken, FIFO_DEPTH)
		lock_en <= 1'b1;
		slow <= 1'b1;
		start_run(2'h0);
		repeat (120) @(posedge clk);
		`CHK(pulses, 0)
		slow <= 1'b0;
		stop_run(1'b0, 1'b1);
		$display("test fifo fill done");
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_pin(2'h1, 0);
		t_pin(2'h2, 40);
		t_reg();
		t_fill();
		print_verdict();
	end
endmodule // tb
